// ==== hw/cmcr_top.sv ====
// Manufacturer configuration register bank with its control consumers
`timescale 1ns/10ps
module cmcr_top
#(
  parameter int MS_TICK_CYCLES = cmcr_pkg::MS_TICK_CYCLES
)
(
  input wire logic CLK_SYS,
  input wire logic SYS_RST,
  input wire logic TXN_START,
  input wire logic [7:0] TXN_CMD,
  input wire logic TXN_WRITE,
  input wire logic WR_VALID,
  input wire logic [7:0] WR_DATA,
  input wire logic RD_REQ,
  input wire logic TXN_STOP,
  output logic RD_VALID,
  output logic [7:0] RD_DATA,
  output logic TXN_DONE,
  output logic TXN_ERROR,
  input wire logic [7:0] RC_ANALOG_LEVEL,
  output logic REMOTE_ON,
  output logic [14:0] KICKSTART_CYCLES,
  input wire logic [7:0] INPUT_OFF_THRESHOLD,
  input wire logic [7:0] INPUT_VOLTAGE,
  output logic [8:0] FAST_INPUT_OFF_LEVEL,
  output logic FAST_INPUT_OFF,
  input wire logic POWER_GOOD_INT,
  output logic POWER_GOOD_PIN,
  input wire logic OCP_SAMPLE_VALID,
  input wire logic [6:0] OCP_SAMPLE_LEVEL,
  output logic OCP_TRIP,
  input wire logic [3:0] FAULT_START,
  input wire logic [31:0] FAULT_COUNTS,
  output logic [3:0] FAULT_BUSY,
  output logic [3:0] FAULT_DONE,
  input wire logic [15:0] TRIM_ON_OFFSET,
  input wire logic [15:0] TRIM_OFF_SCALE,
  input wire logic PREBIAS_REQ,
  input wire logic signed [15:0] INPUT_SLOPE,
  input wire logic signed [15:0] OUTPUT_SLOPE,
  output logic PREBIAS_START_OK,
  output logic [2:0] FILTER_SELECT_ONEHOT
);

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  // Data length of a command, zero when the code is not in this bank
  function automatic logic [3:0] cmd_len(input logic [7:0] cmd);
    case (cmd)
      cmcr_pkg::CMD_RC_THRESHOLD,
      cmcr_pkg::CMD_KS_PRETRIG,
      cmcr_pkg::CMD_FAST_IN_OFF,
      cmcr_pkg::CMD_PG_POLARITY,
      cmcr_pkg::CMD_RESP_UNIT,
      cmcr_pkg::CMD_FILTER_SEL: cmd_len = cmcr_pkg::LEN_BYTE;
      cmcr_pkg::CMD_FAST_OCP: cmd_len = cmcr_pkg::LEN_WORD;
      cmcr_pkg::CMD_SCALE_MON: cmd_len = cmcr_pkg::LEN_SCALE;
      cmcr_pkg::CMD_SLOPE_LIM: cmd_len = cmcr_pkg::LEN_SLOPE;
      default: cmd_len = 4'h0;
    endcase
  endfunction

  // Block transfers carry a leading byte count
  function automatic logic cmd_block(input logic [7:0] cmd);
    cmd_block = (cmd == cmcr_pkg::CMD_SCALE_MON) ||
                (cmd == cmcr_pkg::CMD_SLOPE_LIM);
  endfunction

  function automatic logic signed [15:0] slope_field(
    input logic [63:0] limits,
    input int lsb);
    slope_field = limits[lsb +: cmcr_pkg::SLOPE_W];
  endfunction

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  logic [7:0] rc_threshold_q;
  logic [7:0] ks_pretrig_q;
  logic [7:0] fast_in_off_q;
  logic [7:0] pg_polarity_q;
  logic [15:0] fast_ocp_q;
  logic [7:0] resp_unit_q;
  logic [63:0] slope_lim_q;
  logic [7:0] filter_sel_q;

  logic [7:0] cmd_q;
  logic wr_q;
  logic active_q;
  logic [3:0] idx_q;
  logic [7:0] blk_cnt_q;
  logic [63:0] wbuf_q;
  logic [63:0] cur_val;
  logic [3:0] cur_len;
  logic cur_blk;
  logic [3:0] pos;
  logic wr_ok;

  assign cur_len = cmd_len(cmd_q);
  assign cur_blk = cmd_block(cmd_q);
  assign pos = (cur_blk ? idx_q - 4'h1 : idx_q);

  // The stop commits only a complete transfer of the exact documented size
  assign wr_ok = active_q && wr_q &&
                 (cur_len != 4'h0) &&
                 (cmd_q != cmcr_pkg::CMD_SCALE_MON) &&
                 (idx_q == cur_len + {3'b000, cur_blk}) &&
                 (!cur_blk || blk_cnt_q == {4'h0, cur_len});

  // ----------------------------------------------------------------------
  // Read view
  // ----------------------------------------------------------------------
  always_comb
  begin
    cur_val = '0;
    case (cmd_q)
      cmcr_pkg::CMD_RC_THRESHOLD: cur_val[7:0] = rc_threshold_q;
      cmcr_pkg::CMD_KS_PRETRIG: cur_val[7:0] = ks_pretrig_q;
      cmcr_pkg::CMD_FAST_IN_OFF: cur_val[7:0] = fast_in_off_q;
      cmcr_pkg::CMD_PG_POLARITY: cur_val[7:0] = pg_polarity_q;
      cmcr_pkg::CMD_FAST_OCP:
        cur_val[15:0] = fast_ocp_q & cmcr_pkg::OCP_DEFINED_MASK;
      cmcr_pkg::CMD_RESP_UNIT: cur_val[7:0] = resp_unit_q;
      cmcr_pkg::CMD_SCALE_MON:
      begin
        cur_val[cmcr_pkg::SCALE_ON_LSB +: 16] = TRIM_ON_OFFSET;
        cur_val[cmcr_pkg::SCALE_OFF_LSB +: 16] = TRIM_OFF_SCALE;
      end
      cmcr_pkg::CMD_SLOPE_LIM: cur_val = slope_lim_q;
      cmcr_pkg::CMD_FILTER_SEL: cur_val[7:0] = filter_sel_q;
      default: cur_val = '0;
    endcase
  end

  // ----------------------------------------------------------------------
  // Transaction framing
  // ----------------------------------------------------------------------
  always_ff @(posedge CLK_SYS or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      cmd_q <= 8'h00;
      wr_q <= 1'b0;
      active_q <= 1'b0;
      idx_q <= 4'h0;
      blk_cnt_q <= 8'h00;
      wbuf_q <= '0;
    end
    else if (TXN_START)
    begin
      cmd_q <= TXN_CMD;
      wr_q <= TXN_WRITE;
      active_q <= 1'b1;
      idx_q <= 4'h0;
      blk_cnt_q <= 8'h00;
      wbuf_q <= '0;
    end
    else if (TXN_STOP)
    begin
      active_q <= 1'b0;
    end
    else if (active_q && wr_q && WR_VALID)
    begin
      // Bytes beyond the longest transfer only push the count past valid
      if (idx_q != 4'hF)
        idx_q <= idx_q + 4'h1;
      if (cur_blk && idx_q == 4'h0)
        blk_cnt_q <= WR_DATA;
      else if (pos < 4'h8)
        wbuf_q[pos[2:0]*8 +: 8] <= WR_DATA; // Low byte first
    end
    else if (active_q && !wr_q && RD_REQ)
    begin
      if (idx_q != 4'hF)
        idx_q <= idx_q + 4'h1;
    end
  end

  always_ff @(posedge CLK_SYS or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      RD_VALID <= 1'b0;
      RD_DATA <= 8'h00;
    end
    else
    begin
      RD_VALID <= active_q && !wr_q && RD_REQ && !TXN_START && !TXN_STOP;
      if (active_q && !wr_q && RD_REQ)
      begin
        if (cur_blk && idx_q == 4'h0)
          RD_DATA <= {4'h0, cur_len};
        else if (cur_len != 4'h0 && pos < cur_len)
          RD_DATA <= cur_val[pos[2:0]*8 +: 8];
        else
          RD_DATA <= cmcr_pkg::RD_FILL;
      end
    end
  end

  always_ff @(posedge CLK_SYS or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      TXN_DONE <= 1'b0;
      TXN_ERROR <= 1'b0;
    end
    else
    begin
      TXN_DONE <= TXN_STOP && active_q && !TXN_START;
      TXN_ERROR <= TXN_STOP && active_q && !TXN_START &&
                   (wr_q ? !wr_ok : (cur_len == 4'h0));
    end
  end

  // ----------------------------------------------------------------------
  // Register commit
  // ----------------------------------------------------------------------
  always_ff @(posedge CLK_SYS or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      rc_threshold_q <= cmcr_pkg::RST_BYTE;
      ks_pretrig_q <= cmcr_pkg::RST_BYTE;
      fast_in_off_q <= cmcr_pkg::RST_BYTE;
      pg_polarity_q <= cmcr_pkg::RST_BYTE;
      fast_ocp_q <= cmcr_pkg::RST_OCP;
      resp_unit_q <= cmcr_pkg::RST_BYTE;
      slope_lim_q <= cmcr_pkg::RST_SLOPE;
      filter_sel_q <= cmcr_pkg::RST_BYTE;
    end
    else if (TXN_STOP && !TXN_START && wr_ok)
    begin
      case (cmd_q)
        cmcr_pkg::CMD_RC_THRESHOLD: rc_threshold_q <= wbuf_q[7:0];
        cmcr_pkg::CMD_KS_PRETRIG: ks_pretrig_q <= wbuf_q[7:0];
        cmcr_pkg::CMD_FAST_IN_OFF: fast_in_off_q <= wbuf_q[7:0];
        cmcr_pkg::CMD_PG_POLARITY: pg_polarity_q <= wbuf_q[7:0];
        cmcr_pkg::CMD_FAST_OCP:
          fast_ocp_q <= wbuf_q[15:0] & cmcr_pkg::OCP_DEFINED_MASK;
        cmcr_pkg::CMD_RESP_UNIT: resp_unit_q <= wbuf_q[7:0];
        cmcr_pkg::CMD_SLOPE_LIM: slope_lim_q <= wbuf_q;
        cmcr_pkg::CMD_FILTER_SEL: filter_sel_q <= wbuf_q[7:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Remote control, kickstart and input-off
  // ----------------------------------------------------------------------
  logic [31:0] ks_ns;

  assign ks_ns = cmcr_pkg::KS_BASE_NS +
                 cmcr_pkg::KS_STEP_NS * {24'h00_0000, ks_pretrig_q};

  always_ff @(posedge CLK_SYS or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      REMOTE_ON <= 1'b0;
      KICKSTART_CYCLES <= 15'h0000;
      FAST_INPUT_OFF_LEVEL <= 9'h000;
      FAST_INPUT_OFF <= 1'b0;
    end
    else
    begin
      REMOTE_ON <= (RC_ANALOG_LEVEL >= rc_threshold_q);
      // Rounded up so the pre-trigger is never shorter than programmed
      KICKSTART_CYCLES <= 15'((ks_ns + cmcr_pkg::CLK_PERIOD_NS - 1) /
                              cmcr_pkg::CLK_PERIOD_NS);
      FAST_INPUT_OFF_LEVEL <= {1'b0, INPUT_OFF_THRESHOLD} +
                              {1'b0, fast_in_off_q};
      FAST_INPUT_OFF <= ({1'b0, INPUT_VOLTAGE} <
                         ({1'b0, INPUT_OFF_THRESHOLD} +
                          {1'b0, fast_in_off_q}));
    end
  end

  // ----------------------------------------------------------------------
  // Power-good pin
  // ----------------------------------------------------------------------
  // Until polarity is known the pin shows not-good in the active-low sense
  always_ff @(posedge CLK_SYS or posedge SYS_RST)
  begin
    if (SYS_RST)
      POWER_GOOD_PIN <= 1'b1;
    else if (pg_polarity_q == cmcr_pkg::PG_ACTIVE_HIGH)
      POWER_GOOD_PIN <= POWER_GOOD_INT;
    else
      POWER_GOOD_PIN <= !POWER_GOOD_INT;
  end

  // ----------------------------------------------------------------------
  // Fast overcurrent
  // ----------------------------------------------------------------------
  logic [cmcr_pkg::OCP_CNT_W-1:0] ocp_run_q;
  logic [cmcr_pkg::OCP_CNT_W-1:0] ocp_need;
  logic ocp_en;
  logic ocp_over;

  assign ocp_en = fast_ocp_q[cmcr_pkg::OCP_EN_BIT];
  assign ocp_need = fast_ocp_q[cmcr_pkg::OCP_CNT_LSB +: cmcr_pkg::OCP_CNT_W];
  assign ocp_over = OCP_SAMPLE_LEVEL >=
                    fast_ocp_q[cmcr_pkg::OCP_LVL_W-1:0];

  always_ff @(posedge CLK_SYS or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      ocp_run_q <= '0;
      OCP_TRIP <= 1'b0;
    end
    else if (!ocp_en)
    begin
      ocp_run_q <= '0;
      OCP_TRIP <= 1'b0;
    end
    else if (OCP_SAMPLE_VALID)
    begin
      if (!ocp_over)
      begin
        ocp_run_q <= '0;
        OCP_TRIP <= 1'b0;
      end
      else
      begin
        if (ocp_run_q != '1)
          ocp_run_q <= ocp_run_q + 1'b1;
        // A count of zero is taken as one sample
        OCP_TRIP <= ({1'b0, ocp_run_q} + 6'h01 >= {1'b0, ocp_need});
      end
    end
  end

  // ----------------------------------------------------------------------
  // Fault response timers
  // ----------------------------------------------------------------------
  logic [31:0] ms_cnt_q;
  logic ms_tick_q;

  always_ff @(posedge CLK_SYS or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      ms_cnt_q <= '0;
      ms_tick_q <= 1'b0;
    end
    else if (ms_cnt_q == 32'(MS_TICK_CYCLES - 1))
    begin
      ms_cnt_q <= '0;
      ms_tick_q <= 1'b1;
    end
    else
    begin
      ms_cnt_q <= ms_cnt_q + 32'h0000_0001;
      ms_tick_q <= 1'b0;
    end
  end

  localparam int TB_LSB [cmcr_pkg::FAULT_CLASSES] = '{
    cmcr_pkg::TB_TEMP_LSB, cmcr_pkg::TB_IOUT_LSB,
    cmcr_pkg::TB_VIN_LSB, cmcr_pkg::TB_VOUT_LSB};

  // Class 0 temperature, 1 output current, 2 input voltage, 3 output voltage
  for (genvar g = 0; g < cmcr_pkg::FAULT_CLASSES; g++)
  begin : g_fault
    cmcr_fault_timer u_timer
    (
      .clk(CLK_SYS),
      .rst(SYS_RST),
      .ms_tick(ms_tick_q),
      .unit_code(resp_unit_q[TB_LSB[g] +: cmcr_pkg::TB_W]),
      .count(FAULT_COUNTS[g*8 +: 8]),
      .start(FAULT_START[g]),
      .busy(FAULT_BUSY[g]),
      .done(FAULT_DONE[g])
    );
  end

  // ----------------------------------------------------------------------
  // Pre-bias start check
  // ----------------------------------------------------------------------
  // Negative limits are magnitudes compared against the negated slope
  always_ff @(posedge CLK_SYS or posedge SYS_RST)
  begin
    if (SYS_RST)
      PREBIAS_START_OK <= 1'b0;
    else
      PREBIAS_START_OK <= PREBIAS_REQ &&
        (INPUT_SLOPE <= slope_field(slope_lim_q,
                                    cmcr_pkg::SL_VIN_POS_LSB)) &&
        (-INPUT_SLOPE <= slope_field(slope_lim_q,
                                     cmcr_pkg::SL_VIN_NEG_LSB)) &&
        (OUTPUT_SLOPE <= slope_field(slope_lim_q,
                                     cmcr_pkg::SL_VOUT_POS_LSB)) &&
        (-OUTPUT_SLOPE <= slope_field(slope_lim_q,
                                      cmcr_pkg::SL_VOUT_NEG_LSB));
  end

  // ----------------------------------------------------------------------
  // Filter coefficient selection
  // ----------------------------------------------------------------------
  always_ff @(posedge CLK_SYS or posedge SYS_RST)
  begin
    if (SYS_RST)
      FILTER_SELECT_ONEHOT <= 3'b001;
    else
    begin
      case (filter_sel_q)
        cmcr_pkg::FILT_VOUT: FILTER_SELECT_ONEHOT <= 3'b001;
        cmcr_pkg::FILT_IOUT: FILTER_SELECT_ONEHOT <= 3'b010;
        cmcr_pkg::FILT_FEED_FWD: FILTER_SELECT_ONEHOT <= 3'b100;
        default: FILTER_SELECT_ONEHOT <= 3'b000;
      endcase
    end
  end

endmodule

// ==== hw/cmcr_pkg.sv ====
// Constants shared by the converter configuration register bank
// Function
// - Hold an unsigned byte setting the remote control input trigger threshold.
// - Kickstart pre-trigger time is 20 us plus 450 ns per count.
// - Fast input-off criterion is the input-off threshold plus the programmed offset.
// - Power-good pin is active low for polarity 0, active high for 1.
// - Bit 7 of the fast overcurrent word enables fast overcurrent protection.
// - Trip only after the five-bit count of consecutive overcurrent samples.
// - Seven-bit level is one of 128 steps against the current readout.
// - Time-base codes 0 to 3 give 1 ms, 10 ms, 100 ms, 1 s units.
// - Time-base fields: 7:6 output voltage, 5:4 input, 3:2 current, 1:0 temperature.
// - Fault retry or delay time equals the count times the selected unit.
// - Scale monitor block read: on-state offset in 31:16, off-state scale 15:0.
// - Pre-bias start needs input slope within limits in 63:48 and 47:32.
// - Pre-bias start needs output slope within limits in 31:16 and 15:0.
// - Filter select 0 picks output voltage, 1 output current, 2 feed-forward.
// - Slope limits move only as one eight-byte block write or read; a shorter read is not flagged as an error.
package cmcr_pkg;

  // ----------------------------------------------------------------------
  // Command codes
  // ----------------------------------------------------------------------
  localparam logic [7:0] CMD_RC_THRESHOLD = 8'hC6;
  localparam logic [7:0] CMD_KS_PRETRIG = 8'hC7;
  localparam logic [7:0] CMD_FAST_IN_OFF = 8'hC8;
  localparam logic [7:0] CMD_PG_POLARITY = 8'hD0;
  localparam logic [7:0] CMD_FAST_OCP = 8'hD1;
  localparam logic [7:0] CMD_RESP_UNIT = 8'hD2;
  localparam logic [7:0] CMD_SCALE_MON = 8'hD3;
  localparam logic [7:0] CMD_SLOPE_LIM = 8'hD4;
  localparam logic [7:0] CMD_FILTER_SEL = 8'hD5;

  // ----------------------------------------------------------------------
  // Transfer lengths in data bytes
  // ----------------------------------------------------------------------
  localparam logic [3:0] LEN_BYTE = 4'h1;
  localparam logic [3:0] LEN_WORD = 4'h2;
  localparam logic [3:0] LEN_SCALE = 4'h4;
  localparam logic [3:0] LEN_SLOPE = 4'h8;
  localparam logic [7:0] RD_FILL = 8'hFF;

  // ----------------------------------------------------------------------
  // Field layout
  // ----------------------------------------------------------------------
  localparam logic [15:0] OCP_DEFINED_MASK = 16'h1FFF;
  localparam int OCP_EN_BIT = 7;
  localparam int OCP_CNT_LSB = 8;
  localparam int OCP_CNT_W = 5;
  localparam int OCP_LVL_W = 7;
  localparam int TB_W = 2;
  localparam int TB_VOUT_LSB = 6;
  localparam int TB_VIN_LSB = 4;
  localparam int TB_IOUT_LSB = 2;
  localparam int TB_TEMP_LSB = 0;
  localparam int SLOPE_W = 16;
  localparam int SL_VIN_POS_LSB = 48;
  localparam int SL_VIN_NEG_LSB = 32;
  localparam int SL_VOUT_POS_LSB = 16;
  localparam int SL_VOUT_NEG_LSB = 0;
  localparam int SCALE_ON_LSB = 16;
  localparam int SCALE_OFF_LSB = 0;
  localparam logic [7:0] PG_ACTIVE_HIGH = 8'h01;
  localparam logic [7:0] FILT_VOUT = 8'h00;
  localparam logic [7:0] FILT_IOUT = 8'h01;
  localparam logic [7:0] FILT_FEED_FWD = 8'h02;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_OCP = 16'h0000;
  localparam logic [63:0] RST_SLOPE = 64'h0000_0000_0000_0000;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 8;
  localparam int KS_BASE_NS = 20000;
  localparam int KS_STEP_NS = 450;
  localparam int MS_TICK_NS = 1000000;
  localparam int MS_TICK_CYCLES = MS_TICK_NS / CLK_PERIOD_NS;
  localparam int FAULT_CLASSES = 4;
  localparam int FAULT_MS_W = 18;
  localparam logic [9:0] UNIT_1MS = 10'd1;
  localparam logic [9:0] UNIT_10MS = 10'd10;
  localparam logic [9:0] UNIT_100MS = 10'd100;
  localparam logic [9:0] UNIT_1S = 10'd1000;

endpackage

// ==== hw/cmcr_fault_timer.sv ====
// Fault response retry or delay timer for one fault class
`timescale 1ns/10ps
module cmcr_fault_timer
(
  input wire logic clk,
  input wire logic rst,
  input wire logic ms_tick,
  input wire logic [1:0] unit_code,
  input wire logic [7:0] count,
  input wire logic start,
  output logic busy,
  output logic done
);

  logic [cmcr_pkg::FAULT_MS_W-1:0] remain_q;
  logic [cmcr_pkg::FAULT_MS_W-1:0] total_d;
  logic [9:0] unit_ms;

  // ----------------------------------------------------------------------
  // Unit and total
  // ----------------------------------------------------------------------
  always_comb
  begin
    case (unit_code)
      2'd0: unit_ms = cmcr_pkg::UNIT_1MS;
      2'd1: unit_ms = cmcr_pkg::UNIT_10MS;
      2'd2: unit_ms = cmcr_pkg::UNIT_100MS;
      default: unit_ms = cmcr_pkg::UNIT_1S;
    endcase
    total_d = cmcr_pkg::FAULT_MS_W'(count) *
              cmcr_pkg::FAULT_MS_W'(unit_ms);
  end

  // Unit is sampled at start so a later rewrite does not stretch a wait
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      remain_q <= '0;
      busy <= 1'b0;
      done <= 1'b0;
    end
    else
    begin
      done <= 1'b0;
      if (start)
      begin
        remain_q <= total_d;
        busy <= (total_d != '0);
        done <= (total_d == '0);
      end
      else if (busy && ms_tick)
      begin
        remain_q <= remain_q - 1'b1;
        if (remain_q == 1)
        begin
          busy <= 1'b0;
          done <= 1'b1;
        end
      end
    end
  end

endmodule

// ==== verification/cmcr_chk.sv ====
// Port assertions for the configuration register bank
`timescale 1ns/10ps
module cmcr_chk
#(
  parameter int MS_TICK_CYCLES = cmcr_pkg::MS_TICK_CYCLES
)
(
  input wire logic CLK_SYS,
  input wire logic SYS_RST,
  input wire logic TXN_STOP,
  input wire logic RD_REQ,
  input wire logic RD_VALID,
  input wire logic TXN_DONE,
  input wire logic TXN_ERROR,
  input wire logic [14:0] KICKSTART_CYCLES,
  input wire logic [7:0] INPUT_VOLTAGE,
  input wire logic [8:0] FAST_INPUT_OFF_LEVEL,
  input wire logic FAST_INPUT_OFF,
  input wire logic OCP_SAMPLE_VALID,
  input wire logic OCP_TRIP,
  input wire logic [3:0] FAULT_START,
  input wire logic [3:0] FAULT_BUSY,
  input wire logic PREBIAS_REQ,
  input wire logic PREBIAS_START_OK,
  input wire logic [2:0] FILTER_SELECT_ONEHOT
);
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (SYS_RST);
  a_done_stop:
    assert property (TXN_DONE |-> $past(TXN_STOP))
    else $error("done without a stop");
  a_error_done:
    assert property (TXN_ERROR |-> TXN_DONE)
    else $error("error without done");
  a_read_answer:
    assert property (RD_VALID |-> $past(RD_REQ))
    else $error("read byte without request");
  // Two edges of grace: the output is registered behind the register
  a_kick_range:
    assert property (!$past(SYS_RST, 2) |->
      KICKSTART_CYCLES >= 15'h09C4 && KICKSTART_CYCLES <= 15'h41CC)
    else $error("kickstart time out of range");
  a_fast_off_cmp:
    assert property (FAST_INPUT_OFF ==
      ({1'b0, $past(INPUT_VOLTAGE)} < FAST_INPUT_OFF_LEVEL))
    else $error("fast input off wrong");
  a_ocp_cause:
    assert property ($rose(OCP_TRIP) |-> $past(OCP_SAMPLE_VALID))
    else $error("trip without a sample");
  a_busy_start:
    assert property (((FAULT_BUSY & ~$past(FAULT_BUSY)) &
      ~$past(FAULT_START)) == 4'h0)
    else $error("timer busy without start");
  a_prebias_req:
    assert property (PREBIAS_START_OK |-> $past(PREBIAS_REQ))
    else $error("pre-bias ok without request");
  a_filter_onehot:
    assert property ($onehot0(FILTER_SELECT_ONEHOT))
    else $error("filter select not one-hot");
endmodule

bind cmcr_top cmcr_chk #(.MS_TICK_CYCLES(MS_TICK_CYCLES)) u_chk
(
  .CLK_SYS(CLK_SYS), .SYS_RST(SYS_RST), .TXN_STOP(TXN_STOP),
  .RD_REQ(RD_REQ), .RD_VALID(RD_VALID), .TXN_DONE(TXN_DONE),
  .TXN_ERROR(TXN_ERROR), .KICKSTART_CYCLES(KICKSTART_CYCLES),
  .INPUT_VOLTAGE(INPUT_VOLTAGE), .FAST_INPUT_OFF(FAST_INPUT_OFF),
  .FAST_INPUT_OFF_LEVEL(FAST_INPUT_OFF_LEVEL), .OCP_TRIP(OCP_TRIP),
  .OCP_SAMPLE_VALID(OCP_SAMPLE_VALID), .FAULT_START(FAULT_START),
  .FAULT_BUSY(FAULT_BUSY), .PREBIAS_REQ(PREBIAS_REQ),
  .PREBIAS_START_OK(PREBIAS_START_OK),
  .FILTER_SELECT_ONEHOT(FILTER_SELECT_ONEHOT)
);

// ==== verification/cmcr_host.sv ====
// Host controller model driving the transaction port
`timescale 1ns/10ps
module cmcr_host
(
  input wire logic clk,
  output logic start = 1'b0,
  output logic [7:0] cmd = 8'h00,
  output logic wr = 1'b0,
  output logic wv = 1'b0,
  output logic [7:0] wd = 8'h00,
  output logic rq = 1'b0,
  output logic stop = 1'b0,
  input wire logic rv,
  input wire logic [7:0] rdat,
  input wire logic done,
  input wire logic err
);
  // Bytes go low first, one per cycle; s is {timed out, error}
  task automatic xfer(input logic [7:0] c, input logic w, input int n,
    input logic [71:0] d, output logic [71:0] q, output logic [1:0] s);
    int k;
    int g;
    q = 72'h0;
    g = 0;
    s = 2'h2;
    @(posedge clk);
    start <= 1'b1;
    cmd <= c;
    wr <= w;
    for (k = 0; k < n + 2; k++)
    begin
      @(posedge clk);
      start <= 1'b0;
      if (rv === 1'b1 && g < 9)
      begin
        q[g*8 +: 8] = rdat;
        g++;
      end
      wv <= w && k < n;
      wd <= (k < n) ? d[k*8 +: 8] : 8'h00;
      rq <= !w && k < n;
    end
    @(posedge clk);
    stop <= 1'b1;
    @(posedge clk);
    stop <= 1'b0;
    for (k = 0; k < 4 && s[1]; k++)
    begin
      @(posedge clk);
      if (done === 1'b1)
        s = {1'b0, err};
    end
  endtask
endmodule

// ==== verification/tb_top.sv ====
// Self-checking bench for the configuration register bank
`timescale 1ns/10ps
module tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] rc = 8'h00, thr = 8'h00, vin = 8'h00;
  logic pgi = 1'b0, ov = 1'b0, pq = 1'b0;
  logic [6:0] ol = 7'h00;
  logic [3:0] fs = 4'h0;
  logic [31:0] fc = 32'h0000_0000;
  logic [15:0] ton = 16'h1234, toff = 16'h5678;
  logic signed [15:0] isl = 16'sh0000, osl = 16'sh0000;
  logic st, wr, wv, rq, sp, rv, dn, er, ron, fo, pgp, trip, pok;
  logic [7:0] cmd, wd, rdat;
  logic [14:0] ks;
  logic [8:0] fol;
  logic [3:0] fb, fd;
  logic [2:0] oh;
  logic [71:0] q;
  logic [1:0] s;
  int err_total = 0;
  int num_checks = 0;

  always #4 clk = ~clk;

  cmcr_host host (.clk(clk), .start(st), .cmd(cmd), .wr(wr), .wv(wv),
    .wd(wd), .rq(rq), .stop(sp), .rv(rv), .rdat(rdat), .done(dn), .err(er));

  // Ten-cycle millisecond keeps the one-second unit inside the run
  cmcr_top #(.MS_TICK_CYCLES(10)) dut (.CLK_SYS(clk), .SYS_RST(rst),
    .TXN_START(st), .TXN_CMD(cmd), .TXN_WRITE(wr), .WR_VALID(wv),
    .WR_DATA(wd), .RD_REQ(rq), .TXN_STOP(sp), .RD_VALID(rv),
    .RD_DATA(rdat), .TXN_DONE(dn), .TXN_ERROR(er), .RC_ANALOG_LEVEL(rc),
    .REMOTE_ON(ron), .KICKSTART_CYCLES(ks), .INPUT_OFF_THRESHOLD(thr),
    .INPUT_VOLTAGE(vin), .FAST_INPUT_OFF_LEVEL(fol), .FAST_INPUT_OFF(fo),
    .POWER_GOOD_INT(pgi), .POWER_GOOD_PIN(pgp), .OCP_SAMPLE_VALID(ov),
    .OCP_SAMPLE_LEVEL(ol), .OCP_TRIP(trip), .FAULT_START(fs),
    .FAULT_COUNTS(fc), .FAULT_BUSY(fb), .FAULT_DONE(fd),
    .TRIM_ON_OFFSET(ton), .TRIM_OFF_SCALE(toff), .PREBIAS_REQ(pq),
    .INPUT_SLOPE(isl), .OUTPUT_SLOPE(osl), .PREBIAS_START_OK(pok),
    .FILTER_SELECT_ONEHOT(oh));

  task chk(input logic [71:0] v, input logic [71:0] e);
    num_checks++;
    if (v !== e)
    begin
      err_total++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, v, e);
    end
  endtask

  task tally_and_finish;
    $display("checks=%0d errors=%0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  task w(input logic [7:0] c, input int n, input logic [71:0] d,
    input logic [1:0] es);
    host.xfer(c, 1'b1, n, d, q, s);
    chk(s, es);
    if (s[1])
      tally_and_finish();
  endtask

  task r(input logic [7:0] c, input int n);
    host.xfer(c, 1'b0, n, 72'h0, q, s);
    chk(s, 2'h0);
    if (s[1])
      tally_and_finish();
  endtask

  task smp(input logic [6:0] l);
    @(posedge clk);
    ov <= 1'b1;
    ol <= l;
    @(posedge clk);
    ov <= 1'b0;
  endtask

  task tm(input int g, input int cnt, input int exp);
    int n;
    fc <= 32'(cnt) << (8 * g);
    fs <= 4'h1 << g;
    @(posedge clk);
    fs <= 4'h0;
    @(posedge clk);
    chk(fb[g], 1'h1);
    n = 1;
    while (fd[g] !== 1'b1 && n < 24000)
    begin
      @(posedge clk);
      n++;
    end
    chk(n >= exp - 12 && n <= exp + 12, 1'h1);
    if (n == 24000)
      tally_and_finish();
  endtask

  task t_reset;
    chk(oh, 3'h1);
    chk(pgp, 1'h1);
    r(8'hD1, 2);
    chk(q, 72'h0);
  endtask

  task t_bytes;
    w(8'hC6, 1, 72'h40, 2'h0);
    rc <= 8'h40;
    cyc(3);
    chk(ron, 1'h1);
    rc <= 8'h3F;
    cyc(3);
    chk(ron, 1'h0);
    w(8'hC7, 1, 72'hFF, 2'h0);
    cyc(3);
    chk(ks, 15'h41CC);
    w(8'hC7, 1, 72'h10, 2'h0);
    cyc(3);
    chk(ks, 15'h0D48);
    r(8'hC7, 1);
    chk(q, 72'h10);
    w(8'hC8, 1, 72'h20, 2'h0);
    thr <= 8'h30;
    vin <= 8'h4F;
    cyc(3);
    chk(fol, 9'h050);
    chk(fo, 1'h1);
    vin <= 8'h50;
    cyc(3);
    chk(fo, 1'h0);
  endtask

  task t_pg;
    pgi <= 1'b1;
    w(8'hD0, 1, 72'h0, 2'h0);
    cyc(3);
    chk(pgp, 1'h0);
    w(8'hD0, 1, 72'h1, 2'h0);
    cyc(3);
    chk(pgp, 1'h1);
    pgi <= 1'b0;
    cyc(3);
    chk(pgp, 1'h0);
  endtask

  task t_filter;
    for (int i = 0; i < 4; i++)
    begin
      w(8'hD5, 1, 72'(i), 2'h0);
      cyc(3);
      chk(oh, (i < 3) ? 3'h1 << i : 3'h0);
    end
  endtask

  task t_ocp;
    w(8'hD1, 2, 72'hFF85, 2'h0);
    r(8'hD1, 2);
    chk(q, 72'h1F85);
    w(8'hD1, 2, 72'h0285, 2'h0);
    smp(7'h05);
    cyc(2);
    chk(trip, 1'h0);
    smp(7'h05);
    cyc(2);
    chk(trip, 1'h1);
    smp(7'h04);
    cyc(2);
    chk(trip, 1'h0);
    w(8'hD1, 2, 72'h0205, 2'h0);
    smp(7'h05);
    smp(7'h05);
    cyc(2);
    chk(trip, 1'h0);
  endtask

  task t_time;
    for (int g = 0; g < 4; g++)
    begin
      w(8'hD2, 1, 72'(8'h01 << (2 * g)), 2'h0);
      tm(g, 2, 200);
    end
    for (int c = 0; c < 4; c++)
    begin
      w(8'hD2, 1, 72'(c), 2'h0);
      tm(0, 2, 20 * 10 ** c);
    end
  endtask

  task t_blk;
    r(8'hD3, 5);
    chk(q, 72'h12_3456_7804);
    w(8'hD4, 9, 72'h01_0001_0000_8000_8008, 2'h0);
    w(8'hD4, 5, 72'h1_2345, 2'h1);
    r(8'hD4, 9);
    chk(q, 72'h01_0001_0000_8000_8008);
    w(8'hD3, 4, 72'h0, 2'h1);
    w(8'hD6, 1, 72'h0, 2'h1);
    pq <= 1'b1;
    isl <= 16'sh0100;
    osl <= -16'sh0080;
    cyc(3);
    chk(pok, 1'h1);
    isl <= 16'sh0101;
    cyc(3);
    chk(pok, 1'h0);
    isl <= -16'sh0100;
    osl <= -16'sh0081;
    cyc(3);
    chk(pok, 1'h0);
  endtask

  initial
  begin
    cyc(5);
    rst <= 1'b0;
    t_reset;
    t_bytes;
    t_pg;
    t_filter;
    t_ocp;
    t_time;
    t_blk;
    tally_and_finish;
  end
endmodule
